// ---- core/brf_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brf_params.svh"

module brf_readout (
  input  wire logic        CLK_I,                          // back-end clock
  input  wire logic        RST_I,                          // sync reset, high
  input  wire logic [15:0] SAMPLE_I_I,                     // new I sample
  input  wire logic [15:0] SAMPLE_Q_I,                     // new Q sample
  input  wire logic [15:0] SAMPLE_MAG_I,                   // new magnitude
  input  wire logic [15:0] SAMPLE_PHASE_I,                 // new phase
  input  wire logic [15:0] SAMPLE_FREQ_I,                  // new frequency
  input  wire logic        SAMPLE_VALID_I,                 // sample set offered
  output logic             SAMPLE_READY_O,                 // staging fifo has room
  input  wire logic        CW_WE_I,                        // control word load pulse
  input  wire logic [7:0]  CW_ADDR_I,                      // destination address
  input  wire logic [31:0] CW_DATA_I,                      // control word value
  input  wire logic [2:0]  SEL_I,                          // 16-bit port select
  input  wire logic        HIGH_BYTE_OUTPUT_ENABLE_N_I,    // upper bus read, low
  input  wire logic        LOW_BYTE_OUTPUT_ENABLE_N_I,     // lower bus read, low
  output logic [7:0]       UPPER_BYTE_OUTPUT_BUS_O,        // high byte of word
  output logic [7:0]       LOWER_BYTE_OUTPUT_BUS_O,        // low byte of word
  output logic             UPPER_BYTE_OUTPUT_BUS_OE_O,     // upper bus driven
  output logic             LOWER_BYTE_OUTPUT_BUS_OE_O,     // lower bus driven
  output logic             BUFFER_LEVEL_IRQ_N_O,           // level interrupt, low
  output logic             THRESHOLD_REACHED_N_O           // ready flag, low
);

  brf_pkg::brf_set_t  ram [`BRF_SETS];
  brf_pkg::brf_set_t  stage_data;
  logic               stage_valid;
  logic               stage_take;

  brf_pkg::brf_ptr_t  wr_ptr_ff;
  brf_pkg::brf_ptr_t  rd_ptr_ff;
  brf_pkg::brf_ptr_t  depth;
  brf_pkg::brf_ptr_t  depth_q_ff;
  brf_pkg::brf_ptr_t  threshold;
  logic [31:0]        out_cfg_ff;
  logic [31:0]        mode_ff;
  logic               fifo_mode;
  logic               route16;
  logic               full;
  logic               empty;
  logic               ready_n;
  logic               ptr_reset;
  logic               adv_req;
  logic               do_write;
  logic               do_adv;
  logic               lo_n_q_ff;
  logic               fetch;
  brf_pkg::brf_fetch_e fetch_kind;
  brf_pkg::brf_word_t status_word;
  brf_pkg::brf_word_t fetch_word;
  brf_pkg::brf_byte_t upper_ff;
  brf_pkg::brf_byte_t lower_ff;
  logic               upper_oe_ff;
  logic               lower_oe_ff;
  logic [3:0]         snap_cnt_ff;
  logic [3:0]         irq_cnt_ff;
  logic [3:0]         nxt_irq_cnt;
  logic               irq_n_ff;
  logic               ready_n_ff;
  logic               irq_trigger;

  function automatic brf_pkg::brf_ptr_t ptr_dist(input brf_pkg::brf_ptr_t w, input brf_pkg::brf_ptr_t r);
    ptr_dist = w - r;
  endfunction : ptr_dist

  function automatic brf_pkg::brf_word_t pick_word(input brf_pkg::brf_set_t s, input logic [2:0] sel);
    case (sel)
      `BRF_SEL_I:     pick_word = s[15:0];
      `BRF_SEL_Q:     pick_word = s[31:16];
      `BRF_SEL_MAG:   pick_word = s[47:32];
      `BRF_SEL_PHASE: pick_word = s[63:48];
      `BRF_SEL_FREQ:  pick_word = s[79:64];
      default:        pick_word = 16'h0000;
    endcase
  endfunction : pick_word

  // staging fifo absorbs bursts while the ring is full; its ready stalls the source
  brf_fifo #(
    .WIDTH (80),
    .DEPTH (8)
  ) u_stage (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (SAMPLE_VALID_I),
    .in_data_i   ({SAMPLE_FREQ_I, SAMPLE_PHASE_I, SAMPLE_MAG_I, SAMPLE_Q_I, SAMPLE_I_I}),
    .in_ready_o  (SAMPLE_READY_O),
    .out_valid_o (stage_valid),
    .out_data_o  (stage_data),
    .out_ready_i (stage_take)
  );

  // control words
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      out_cfg_ff <= `BRF_CW_RST_VAL;
      mode_ff    <= `BRF_CW_RST_VAL;
    end
    else if (CW_WE_I)
    begin
      if (CW_ADDR_I == `BRF_CW_OUT_CFG)
      begin
        out_cfg_ff <= CW_DATA_I;
      end
      if (CW_ADDR_I == `BRF_CW_MODE)
      begin
        mode_ff <= CW_DATA_I;
      end
    end
  end

  assign route16   = ~out_cfg_ff[`BRF_CFG_SERIAL_BIT] & out_cfg_ff[`BRF_CFG_PAR_BIT];
  assign fifo_mode = mode_ff[`BRF_MODE_FIFO_BIT];
  assign threshold = mode_ff[`BRF_MODE_THR_MSB:`BRF_MODE_THR_LSB];

  // pointer state
  assign depth     = ptr_dist(wr_ptr_ff, rd_ptr_ff);
  assign full      = (depth == `BRF_FULL_DIST);
  assign empty     = (depth == `BRF_EMPTY_DIST);
  assign ptr_reset = CW_WE_I & (CW_ADDR_I == `BRF_CW_PTR_RST);

  // falling low-byte enable is the only fetch strobe
  assign fetch = lo_n_q_ff & ~LOW_BYTE_OUTPUT_ENABLE_N_I & route16;

  always_comb
  begin
    case (SEL_I)
      `BRF_SEL_I, `BRF_SEL_Q, `BRF_SEL_MAG, `BRF_SEL_PHASE, `BRF_SEL_FREQ:
        fetch_kind = brf_pkg::BRF_FETCH_DATA;
      `BRF_SEL_STATUS:
        fetch_kind = brf_pkg::BRF_FETCH_STATUS;
      `BRF_SEL_ADVANCE:
        fetch_kind = brf_pkg::BRF_FETCH_ADVANCE;
      default:
        fetch_kind = brf_pkg::BRF_FETCH_NONE;
    endcase
  end

  assign adv_req = (fetch & (fetch_kind == brf_pkg::BRF_FETCH_ADVANCE))
                 | (CW_WE_I & (CW_ADDR_I == `BRF_CW_RD_ADV));

  // a write and an advance in one cycle keep the distance, so both checks use the old one
  assign do_write   = stage_valid & ~full & ~ptr_reset;
  assign do_adv     = adv_req & ~empty & ~ptr_reset;
  assign stage_take = do_write;

  always_ff @(posedge CLK_I)
  begin
    if (do_write)
    begin
      ram[wr_ptr_ff] <= stage_data;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      wr_ptr_ff <= `BRF_WR_PTR_RST;
      rd_ptr_ff <= `BRF_RD_PTR_RST;
    end
    else if (ptr_reset)
    begin
      wr_ptr_ff <= `BRF_WR_PTR_RST;
      rd_ptr_ff <= `BRF_RD_PTR_RST;
    end
    else
    begin
      if (do_write)
      begin
        wr_ptr_ff <= wr_ptr_ff + 3'h1;
      end
      if (do_adv)
      begin
        rd_ptr_ff <= rd_ptr_ff + 3'h1;
      end
    end
  end

  // snapshot ready counts sets captured since the last pointer reset
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || ptr_reset)
    begin
      snap_cnt_ff <= 4'h0;
    end
    else if (do_write && snap_cnt_ff != `BRF_SNAP_CNT_MAX)
    begin
      snap_cnt_ff <= snap_cnt_ff + 4'h1;
    end
  end

  assign ready_n = fifo_mode ? ~(depth > threshold)
                             : ~(snap_cnt_ff >= mode_ff[`BRF_MODE_CNT_MSB:`BRF_MODE_CNT_LSB]);

  always_comb
  begin
    status_word = 16'h0000;
    status_word[8+`BRF_ST_DEPTH_MSB:8+`BRF_ST_DEPTH_LSB] = depth;
    status_word[8+`BRF_ST_EMPTY_BIT] = empty;
    status_word[8+`BRF_ST_FULL_BIT]  = full;
    status_word[8+`BRF_ST_READY_BIT] = ready_n;
  end

  always_comb
  begin
    case (fetch_kind)
      brf_pkg::BRF_FETCH_DATA:   fetch_word = pick_word(ram[rd_ptr_ff], SEL_I);
      brf_pkg::BRF_FETCH_STATUS: fetch_word = status_word;
      default:                   fetch_word = 16'h0000;
    endcase
  end

  // output latch holds between fetches, so a high-byte-only read sees old data
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      lo_n_q_ff <= 1'b1;
      upper_ff  <= 8'h00;
      lower_ff  <= 8'h00;
    end
    else
    begin
      lo_n_q_ff <= LOW_BYTE_OUTPUT_ENABLE_N_I;
      if (fetch)
      begin
        upper_ff <= fetch_word[15:8];
        lower_ff <= fetch_word[7:0];
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      upper_oe_ff <= 1'b0;
      lower_oe_ff <= 1'b0;
    end
    else
    begin
      upper_oe_ff <= route16 & ~HIGH_BYTE_OUTPUT_ENABLE_N_I;
      lower_oe_ff <= route16 & ~LOW_BYTE_OUTPUT_ENABLE_N_I;
    end
  end

  // interrupt: a trigger during a running pulse is dropped so the pulse stays exact
  assign irq_trigger = fifo_mode & (depth > threshold) & (depth_q_ff <= threshold);

  always_comb
  begin
    nxt_irq_cnt = irq_cnt_ff;
    if (irq_cnt_ff != 4'h0)
    begin
      nxt_irq_cnt = irq_cnt_ff - 4'h1;
    end
    else if (irq_trigger)
    begin
      nxt_irq_cnt = `BRF_IRQ_LOW_CYCLES;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      depth_q_ff <= `BRF_EMPTY_DIST;
      irq_cnt_ff <= 4'h0;
      irq_n_ff   <= 1'b1;
      ready_n_ff <= 1'b1;
    end
    else
    begin
      depth_q_ff <= depth;
      irq_cnt_ff <= nxt_irq_cnt;
      irq_n_ff   <= (nxt_irq_cnt == 4'h0);
      ready_n_ff <= ready_n;
    end
  end

  assign UPPER_BYTE_OUTPUT_BUS_O    = upper_ff;
  assign LOWER_BYTE_OUTPUT_BUS_O    = lower_ff;
  assign UPPER_BYTE_OUTPUT_BUS_OE_O = upper_oe_ff;
  assign LOWER_BYTE_OUTPUT_BUS_OE_O = lower_oe_ff;
  assign BUFFER_LEVEL_IRQ_N_O       = irq_n_ff;
  assign THRESHOLD_REACHED_N_O      = ready_n_ff;

  ptr_distinct_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_ptr_ff != rd_ptr_ff)
    else $error("read and write pointers coincide");

  full_blocks_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (full && !ptr_reset) |=> (wr_ptr_ff == $past(wr_ptr_ff)))
    else $error("write pointer moved while full");

  empty_blocks_adv_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (empty && !ptr_reset) |=> (rd_ptr_ff == $past(rd_ptr_ff)))
    else $error("read pointer moved while empty");

  ptr_reset_word_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ptr_reset |=> (wr_ptr_ff == 3'h0) && (rd_ptr_ff == 3'h7))
    else $error("pointer reset word gave wrong pointers");

  adv_step_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fetch && SEL_I == 3'h7 && !empty && !ptr_reset) |=> (rd_ptr_ff == $past(rd_ptr_ff) + 3'h1))
    else $error("select 7 read did not advance");

  status_word_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fetch && SEL_I == 3'h6)
    |=> (UPPER_BYTE_OUTPUT_BUS_O == {$past(depth), $past(empty), $past(full), $past(ready_n), 2'b00})
        && (LOWER_BYTE_OUTPUT_BUS_O == 8'h00))
    else $error("status word wrong on output buses");

  hold_no_fetch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !fetch |=> $stable(UPPER_BYTE_OUTPUT_BUS_O) && $stable(LOWER_BYTE_OUTPUT_BUS_O))
    else $error("output data changed without a low-byte fetch");

  unused_sel_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (fetch && SEL_I == 3'h5 && !CW_WE_I)
    |=> (UPPER_BYTE_OUTPUT_BUS_O == 8'h00) && (LOWER_BYTE_OUTPUT_BUS_O == 8'h00)
        && $stable(rd_ptr_ff))
    else $error("unused select did not read as zero");

  irq_width_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(irq_n_ff) |-> (!irq_n_ff) [*8] ##1 irq_n_ff)
    else $error("interrupt pulse not eight clocks");

  irq_start_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (irq_trigger && irq_cnt_ff == 4'h0) |=> !irq_n_ff)
    else $error("threshold crossing raised no interrupt");

endmodule : brf_readout

`default_nettype wire

// ---- core/brf_params.svh ----
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH

// select codes on the 16-bit read port
`define BRF_SEL_I           3'h0
`define BRF_SEL_Q           3'h1
`define BRF_SEL_MAG         3'h2
`define BRF_SEL_PHASE       3'h3
`define BRF_SEL_FREQ        3'h4
`define BRF_SEL_UNUSED      3'h5
`define BRF_SEL_STATUS      3'h6
`define BRF_SEL_ADVANCE     3'h7

// status word layout on the upper byte bus
`define BRF_ST_DEPTH_MSB    7
`define BRF_ST_DEPTH_LSB    5
`define BRF_ST_EMPTY_BIT    4
`define BRF_ST_FULL_BIT     3
`define BRF_ST_READY_BIT    2

// pointer reset values and pointer distances
`define BRF_WR_PTR_RST      3'h0
`define BRF_RD_PTR_RST      3'h7
`define BRF_FULL_DIST       3'h7
`define BRF_EMPTY_DIST      3'h1
`define BRF_SETS            8

// control word destination addresses
`define BRF_CW_OUT_CFG      8'h14
`define BRF_CW_MODE         8'h15
`define BRF_CW_PTR_RST      8'h16
`define BRF_CW_RD_ADV       8'h17
`define BRF_CW_RST_VAL      32'h0000_0000

// control word field positions
`define BRF_CFG_SERIAL_BIT  25
`define BRF_CFG_PAR_BIT     24
`define BRF_MODE_FIFO_BIT   15
`define BRF_MODE_THR_MSB    14
`define BRF_MODE_THR_LSB    12
`define BRF_MODE_CNT_MSB    3
`define BRF_MODE_CNT_LSB    0

// timing
`define BRF_IRQ_LOW_CYCLES  4'h8
`define BRF_SNAP_CNT_MAX    4'h8

`endif

// ---- core/brf_pkg.sv ----
`default_nettype none

package brf_pkg;

  typedef logic [15:0] brf_word_t;
  typedef logic [7:0]  brf_byte_t;
  typedef logic [2:0]  brf_ptr_t;
  typedef logic [79:0] brf_set_t;

  // what a falling low-byte enable asks for
  typedef enum logic [1:0] {
    BRF_FETCH_DATA,
    BRF_FETCH_STATUS,
    BRF_FETCH_ADVANCE,
    BRF_FETCH_NONE
  } brf_fetch_e;

endpackage : brf_pkg

`default_nettype wire

// ---- core/brf_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

// depth must be a power of two so the index wraps by itself
module brf_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,     // clock
  input  wire logic             rst_i,     // sync reset, high
  input  wire logic             in_valid_i,// source has a word
  input  wire logic [WIDTH-1:0] in_data_i, // source word
  output logic                  in_ready_o,// room for a word
  output logic                  out_valid_o,// word available
  output logic      [WIDTH-1:0] out_data_o,// oldest word
  input  wire logic             out_ready_i // sink takes word
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx_ff;
  logic [AW-1:0]    rd_idx_ff;
  logic [CW-1:0]    count_ff;
  logic [CW-1:0]    nxt_count;
  logic             ready_ff;
  logic             push;
  logic             pop;

  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_idx_ff];
  assign in_ready_o  = ready_ff;
  assign push        = in_valid_i & ready_ff;
  assign pop         = out_valid_o & out_ready_i;
  assign nxt_count   = count_ff + CW'(push) - CW'(pop);

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_idx_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_ff <= wr_idx_ff + 1'b1;
      end
      if (pop)
      begin
        rd_idx_ff <= rd_idx_ff + 1'b1;
      end
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != CW'(DEPTH));
    end
  end

endmodule : brf_fifo

`default_nettype wire

// ---- dv/brf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// 16-bit host on the read port; one read per request, done held for one cycle
module brf_host_model (
  input  wire logic        clk_i,     // back-end clock
  input  wire logic        req_i,     // read wanted
  input  wire logic [2:0]  req_sel_i, // select to read
  output logic [2:0]       sel_o,     // select pins
  output logic             hi_n_o,    // upper enable, low
  output logic             lo_n_o,    // lower enable, low
  input  wire logic [7:0]  upper_i,   // upper bus
  input  wire logic [7:0]  lower_i,   // lower bus
  input  wire logic [1:0]  oe_i,      // bus drivers on
  output logic [15:0]      word_o,    // captured word
  output logic [1:0]       oe_o,      // drivers seen at capture
  output logic             done_o     // read finished
);
  initial
  begin
    sel_o = 3'h0;
    hi_n_o = 1'b1;
    lo_n_o = 1'b1;
    word_o = 16'h0000;
    oe_o = 2'h0;
    done_o = 1'b0;
  end

  always
  begin
    @(negedge clk_i);
    if (req_i)
    begin
      sel_o = req_sel_i;
      @(negedge clk_i);
      hi_n_o = 1'b0;
      lo_n_o = 1'b0; // falling low enable is the fetch
      @(negedge clk_i);
      word_o = {upper_i, lower_i};
      oe_o = oe_i;
      hi_n_o = 1'b1;
      lo_n_o = 1'b1;
      // an advance needs 4 clocks before data may be read again
      repeat ((sel_o == 3'h7) ? 4 : 1) @(negedge clk_i);
      done_o = 1'b1;
      @(negedge clk_i);
      done_o = 1'b0;
    end
  end
endmodule : brf_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brf_params.svh"

module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [79:0] smp = 80'h0;
  logic        valid = 1'b0;
  logic        ready;
  logic        cw_we = 1'b0;
  logic [7:0]  cw_addr = 8'h00;
  logic [31:0] cw_data = 32'h0;
  logic [2:0]  sel;
  logic        hi_n;
  logic        lo_n;
  logic [7:0]  up;
  logic [7:0]  lw;
  logic        oe_u;
  logic        oe_l;
  logic        irq_n;
  logic        thr_n;
  logic        req = 1'b0;
  logic [2:0]  req_sel = 3'h0;
  logic [15:0] word;
  logic [1:0]  oe2;
  logic        done;
  logic [79:0] q[$];
  logic [79:0] pend[$];
  logic [79:0] cur = 80'h0;
  logic [15:0] e;
  int          fifo_mode = 0;
  int          thr = 0;
  int          snap = 0;
  int          cnt = 0;
  int          exp_pulses = 0;
  int          pulses = 0;
  int          lowc = 0;
  int          cyc = 0;
  int          num_errors = 0;
  int          tests_run = 0;
  int unsigned seed;

  always #4 clk = ~clk;

  brf_readout brf_readout_i (
    .CLK_I(clk), .RST_I(rst),
    .SAMPLE_I_I(smp[79:64]), .SAMPLE_Q_I(smp[63:48]), .SAMPLE_MAG_I(smp[47:32]),
    .SAMPLE_PHASE_I(smp[31:16]), .SAMPLE_FREQ_I(smp[15:0]),
    .SAMPLE_VALID_I(valid), .SAMPLE_READY_O(ready),
    .CW_WE_I(cw_we), .CW_ADDR_I(cw_addr), .CW_DATA_I(cw_data), .SEL_I(sel),
    .HIGH_BYTE_OUTPUT_ENABLE_N_I(hi_n), .LOW_BYTE_OUTPUT_ENABLE_N_I(lo_n),
    .UPPER_BYTE_OUTPUT_BUS_O(up), .LOWER_BYTE_OUTPUT_BUS_O(lw),
    .UPPER_BYTE_OUTPUT_BUS_OE_O(oe_u), .LOWER_BYTE_OUTPUT_BUS_OE_O(oe_l),
    .BUFFER_LEVEL_IRQ_N_O(irq_n), .THRESHOLD_REACHED_N_O(thr_n));

  brf_host_model brf_host_model_i (
    .clk_i(clk), .req_i(req), .req_sel_i(req_sel), .sel_o(sel), .hi_n_o(hi_n),
    .lo_n_o(lo_n), .upper_i(up), .lower_i(lw), .oe_i({oe_u, oe_l}),
    .word_o(word), .oe_o(oe2), .done_o(done));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // status as the ring should report it: depth is stored sets plus one
  function automatic logic [15:0] status_exp();
    int d;
    d = q.size() + 1;
    return {d[2:0], q.size() == 0, q.size() == 6, !(fifo_mode != 0 ? d > thr : snap >= cnt), 2'b00, 8'h00};
  endfunction : status_exp

  // staged sets move into the ring while it has room
  task automatic settle();
    while (q.size() < 6 && pend.size() > 0)
    begin
      if (fifo_mode != 0 && q.size() + 1 == thr)
        exp_pulses++;
      q.push_back(pend.pop_front());
      snap++;
    end
  endtask : settle

  task automatic cw(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    cw_we = 1'b1;
    cw_addr = a;
    cw_data = d;
    @(negedge clk);
    cw_we = 1'b0;
  endtask : cw

  task automatic rd(input logic [2:0] s);
    @(negedge clk);
    req <= 1'b1;
    req_sel <= s;
    do @(posedge clk); while (done !== 1'b1);
    @(negedge clk);
    req <= 1'b0;
  endtask : rd

  task automatic push(input int n);
    repeat (n)
    begin
      @(negedge clk);
      for (int k = 0; k < 5; k++)
        smp[16*k +: 16] = 16'($urandom);
      valid = 1'b1;
      while (ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      valid = 1'b0;
      pend.push_back(smp);
    end
    settle();
    repeat (8 + 2 * n) @(negedge clk);
  endtask : push

  task automatic status_chk();
    rd(`BRF_SEL_STATUS);
    e = status_exp();
    check("status", word, e);
    check("ready pin", {15'h0, thr_n}, {15'h0, e[10]});
    check("sample ready", {15'h0, ready}, {15'h0, pend.size() < 8});
  endtask : status_chk

  // every set is opened by an advance, then selects 0 to 5 are read
  task automatic drain();
    while (q.size() > 0)
    begin
      if (q.size() % 2)
        rd(`BRF_SEL_ADVANCE);
      else
      begin
        cw(`BRF_CW_RD_ADV, 32'h0);
        repeat (4) @(negedge clk);
      end
      cur = q.pop_front();
      settle();
      for (int k = 0; k < 6; k++)
      begin
        rd(k[2:0]);
        check("word", word, (k < 5) ? cur[79-16*k -: 16] : 16'h0000);
      end
    end
  endtask : drain

  always @(posedge clk)
  begin
    cyc++;
    if (rst)
      lowc = 0;
    else if (irq_n === 1'b0)
      lowc++;
    else if (lowc != 0)
    begin
      check("irq width", lowc[15:0], 16'h0008);
      pulses++;
      lowc = 0;
    end
    if (cyc > 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  initial
  begin
    seed = $urandom(32'h3d1687c0);
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(`BRF_SEL_STATUS);
    check("oe off", {14'h0, oe2}, 16'h0000);
    check("bus off", word, 16'h0000);
    cw(`BRF_CW_OUT_CFG, 32'h0300_0000);
    rd(`BRF_SEL_STATUS);
    check("oe serial", {14'h0, oe2}, 16'h0000);
    cw(`BRF_CW_OUT_CFG, 32'h0100_0000);
    status_chk();
    check("oe on", {14'h0, oe2}, 16'h0003);
    $display("test route done");
    cw(`BRF_CW_MODE, 32'h0000_b000);
    fifo_mode = 1;
    thr = 3;
    status_chk();
    push(5);
    status_chk();
    drain();
    rd(`BRF_SEL_ADVANCE);
    rd(`BRF_SEL_I);
    check("empty hold", word, cur[79:64]);
    status_chk();
    $display("test fifo done");
    push(10);
    status_chk();
    drain();
    $display("test full done");
    push(2);
    cw(`BRF_CW_PTR_RST, 32'h0);
    q.delete();
    snap = 0;
    repeat (4) @(negedge clk);
    status_chk();
    repeat (12) @(negedge clk);
    check("irq count", pulses[15:0], exp_pulses[15:0]);
    $display("test reset done");
    // snapshot mode: ready flag waits for the programmed number of sets
    cw(`BRF_CW_MODE, 32'h0000_0002);
    fifo_mode = 0;
    cnt = 2;
    status_chk();
    push(2);
    status_chk();
    $display("test snapshot done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
